// [sweep_trigger_control.sv]
// sweep sequencing and trigger qualification with a wishbone slave
// assumes: one clock mclk, all inputs already synchronous to it
`timescale 1ns/1ps
`include "swtc_regs.svh"

module sweep_trigger_control
  import swtc_pkg::*;
#(
  parameter int MS_CYCLES = `SWTC_MS_NS / `SWTC_CLK_NS
)(
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire swtc_wbreq_type wbReq,
  output logic                wbAck,
  output logic [31:0]         wbDat,
  input  wire logic           extTrigIn,
  input  wire logic           videoAboveLevel,
  input  wire logic           ifLevelAboveLevel,
  input  wire logic           satnavSecondPulse,
  output logic                sweepStartPulse,
  output logic                alignPulse,
  output logic                sweepActive,
  output logic                longSweepAlert,
  output logic                uncalibratedFlag,
  output logic                trigNoticeFlag,
  output logic                manualTimeFlag,
  output logic                zeroSpanActive,
  output logic [31:0]         preTrigCycles
);

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] ctrl_q, delay_q, period_q, offset_q, acq_q, autoAcq_q;
  logic [31:0] baseMs_q, zsTime_q, span_q, lastSpan_q;
  logic        notice_q;
  logic [31:0] readMux;
  logic [31:0] wrData;

  // merge write data into the old word under the byte enables
  function automatic logic [31:0] wbMerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // write takes effect on the edge where ack is seen high
  wire busReq  = wbReq.cyc & wbReq.stb;
  wire wrStrb  = busReq & wbReq.we & ack_q;
  function automatic logic hitWr(input logic [5:0] a,
                                 input logic [5:0] off,
                                 input logic       s);
    return s & (a == off);
  endfunction
  wire wrCtrl   = hitWr(wbReq.adr, `SWTC_OFF_CTRL, wrStrb);
  wire wrDelay  = hitWr(wbReq.adr, `SWTC_OFF_DELAY, wrStrb);
  wire wrPeriod = hitWr(wbReq.adr, `SWTC_OFF_PERIOD, wrStrb);
  wire wrOffset = hitWr(wbReq.adr, `SWTC_OFF_OFFSET, wrStrb);
  wire wrAcq    = hitWr(wbReq.adr, `SWTC_OFF_ACQ, wrStrb);
  wire wrAuto   = hitWr(wbReq.adr, `SWTC_OFF_AUTOACQ, wrStrb);
  wire wrBase   = hitWr(wbReq.adr, `SWTC_OFF_BASEMS, wrStrb);
  wire wrZs     = hitWr(wbReq.adr, `SWTC_OFF_ZSTIME, wrStrb);
  wire wrSpan   = hitWr(wbReq.adr, `SWTC_OFF_SPAN, wrStrb);
  wire wrToggle = hitWr(wbReq.adr, `SWTC_OFF_TOGGLE, wrStrb);
  wire wrStatus = hitWr(wbReq.adr, `SWTC_OFF_STATUS, wrStrb);

  // acquisition value is clamped into its legal range on write
  wire [31:0] acqIn  = wbMerge(acq_q, wbReq.dat, wbReq.sel);
  wire [31:0] acqLim = (acqIn < `SWTC_ACQ_MIN) ? `SWTC_ACQ_MIN :
                       (acqIn > `SWTC_ACQ_MAX) ? `SWTC_ACQ_MAX :
                       acqIn;
  wire [31:0] autoIn  = wbMerge(autoAcq_q, wbReq.dat, wbReq.sel);
  wire [31:0] autoLim = (autoIn < `SWTC_ACQ_MIN) ? `SWTC_ACQ_MIN :
                        (autoIn > `SWTC_ACQ_MAX) ? `SWTC_ACQ_MAX :
                        autoIn;
  assign wrData = wbMerge(span_q, wbReq.dat, wbReq.sel);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq & ~ack_q;
      dat_q <= (busReq & ~ack_q) ? readMux : dat_q;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q    <= 32'h0000_0000;
      delay_q   <= 32'h0000_0000;
      period_q  <= `SWTC_RST_PERIOD;
      offset_q  <= 32'h0000_0000;
      acq_q     <= `SWTC_RST_ONE;
      autoAcq_q <= `SWTC_RST_ONE;
      baseMs_q  <= `SWTC_RST_ONE;
      zsTime_q  <= `SWTC_RST_ONE;
    end else begin
      if (wrCtrl)   ctrl_q    <= wbMerge(ctrl_q, wbReq.dat, wbReq.sel);
      if (wrDelay)  delay_q   <= wbMerge(delay_q, wbReq.dat, wbReq.sel);
      if (wrPeriod) period_q  <= wbMerge(period_q, wbReq.dat, wbReq.sel);
      if (wrOffset) offset_q  <= wbMerge(offset_q, wbReq.dat, wbReq.sel);
      if (wrAcq)    acq_q     <= acqLim;
      if (wrAuto)   autoAcq_q <= autoLim;
      if (wrBase)   baseMs_q  <= wbMerge(baseMs_q, wbReq.dat, wbReq.sel);
      if (wrZs)     zsTime_q  <= wbMerge(zsTime_q, wbReq.dat, wbReq.sel);
    end
  end

  // span: a nonzero write is remembered for the toggle command
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      span_q     <= 32'h0000_0000;
      lastSpan_q <= 32'h0000_0000;
    end else if (wrSpan) begin
      span_q     <= wrData;
      lastSpan_q <= (wrData != 32'h0000_0000) ? wrData : lastSpan_q;
    end else if (wrToggle) begin
      span_q <= (span_q == 32'h0000_0000) ? lastSpan_q
                                          : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------
  wire swtc_trig_type trigType =
    swtc_trig_type'(ctrl_q[`SWTC_CTRL_TYP_HI:`SWTC_CTRL_TYP_LO]);
  wire swtc_sync_type syncSel =
    swtc_sync_type'(ctrl_q[`SWTC_CTRL_SYN_HI:`SWTC_CTRL_SYN_LO]);
  wire runEn    = ctrl_q[`SWTC_CTRL_RUN];
  wire negSlope = ctrl_q[`SWTC_CTRL_NEG];
  wire stepped  = ctrl_q[`SWTC_CTRL_STEP];
  wire manAcq   = ctrl_q[`SWTC_CTRL_MAN];
  wire bigModel = ctrl_q[`SWTC_CTRL_BIG];
  wire isPer    = (trigType == TRG_PER);
  wire knownTyp = (trigType == TRG_EXT) | isPer |
                  (trigType == TRG_VIDEO) | (trigType == TRG_IFLVL);
  // stepped sweeps have no trigger behaviour at all
  wire effFree  = stepped | ~knownTyp;
  wire noticeSet = stepped & (trigType != TRG_FREE);
  wire zeroSpan = (span_q == 32'h0000_0000);

  // the manual factor never goes below the automatic floor
  wire [31:0] effAcq = (manAcq && acq_q > autoAcq_q) ? acq_q
                                                     : autoAcq_q;
  wire [31:0] zsMax  = bigModel ? `SWTC_ZS_BIG_MS : `SWTC_ZS_SMALL_MS;
  wire [31:0] zsEff  = (zsTime_q > zsMax) ? zsMax : zsTime_q;
  wire [63:0] nzProd = 64'(baseMs_q) * 64'(effAcq);
  // factor only scales nonzero spans; product saturates to 32 bits
  wire [31:0] nzMs   = (nzProd[63:32] != 32'h0000_0000) ?
                       32'hFFFF_FFFF : nzProd[31:0];
  wire [31:0] sweepMs = zeroSpan ? zsEff : nzMs;

  // status read image
  wire [31:0] statusWord = {{26{1'b0}}, zeroSpan, manAcq, notice_q,
                            uncalibratedFlag, longSweepAlert,
                            sweepActive};

  // read mux; unmapped offsets answer zero
  assign readMux =
    (wbReq.adr == `SWTC_OFF_CTRL)    ? ctrl_q     :
    (wbReq.adr == `SWTC_OFF_DELAY)   ? delay_q    :
    (wbReq.adr == `SWTC_OFF_PERIOD)  ? period_q   :
    (wbReq.adr == `SWTC_OFF_OFFSET)  ? offset_q   :
    (wbReq.adr == `SWTC_OFF_ACQ)     ? effAcq     :
    (wbReq.adr == `SWTC_OFF_AUTOACQ) ? autoAcq_q  :
    (wbReq.adr == `SWTC_OFF_BASEMS)  ? baseMs_q   :
    (wbReq.adr == `SWTC_OFF_ZSTIME)  ? zsEff      :
    (wbReq.adr == `SWTC_OFF_SPAN)    ? span_q     :
    (wbReq.adr == `SWTC_OFF_STATUS)  ? statusWord :
    (wbReq.adr == `SWTC_OFF_SWPMS)   ? sweepMs    :
    32'h0000_0000;

  // ------------------------------------------------------------
  // trigger qualification
  // ------------------------------------------------------------
  logic ext_q, vid_q, ifl_q, sat_q;
  logic [31:0] perCnt_q;

  // edge chosen by slope; inputs are already in the mclk domain
  function automatic logic edgeHit(input logic now, input logic prev,
                                   input logic neg);
    return neg ? (prev & ~now) : (now & ~prev);
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_q <= 1'b0;
      vid_q <= 1'b0;
      ifl_q <= 1'b0;
      sat_q <= 1'b0;
    end else begin
      ext_q <= extTrigIn;
      vid_q <= videoAboveLevel;
      ifl_q <= ifLevelAboveLevel;
      sat_q <= satnavSecondPulse;
    end
  end

  wire extEdge = edgeHit(extTrigIn, ext_q, negSlope);
  wire vidEdge = edgeHit(videoAboveLevel, vid_q, negSlope);
  wire iflEdge = edgeHit(ifLevelAboveLevel, ifl_q, negSlope);
  wire satRise = satnavSecondPulse & ~sat_q;

  // sync events act on the periodic phase only in periodic mode
  wire syncHit = isPer & (
    ((syncSel == SYN_EXT)   & extTrigIn & ~ext_q) |
    ((syncSel == SYN_IFLVL) & ifLevelAboveLevel & ~ifl_q) |
    ((syncSel == SYN_SAT)   & satRise));
  wire [31:0] perLast = (period_q == 32'h0000_0000) ?
                        32'h0000_0000 : period_q - 32'h0000_0001;
  // an offset at or beyond a nonzero period never matches
  wire perHit = isPer & (perCnt_q == offset_q);

  // period counter, restarted from zero by the sync source
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      perCnt_q <= 32'h0000_0000;
    end else if (syncHit || perCnt_q >= perLast) begin
      perCnt_q <= 32'h0000_0000;
    end else begin
      perCnt_q <= perCnt_q + 32'h0000_0001;
    end
  end

  // slope plays no part when the type is periodic
  wire trigHit = isPer ? perHit :
    ((trigType == TRG_EXT)   & extEdge) |
    ((trigType == TRG_VIDEO) & vidEdge) |
    ((trigType == TRG_IFLVL) & iflEdge);

  // ------------------------------------------------------------
  // sweep sequencer
  // ------------------------------------------------------------
  swtc_state_type state_q, state_d;
  logic [31:0] delayCnt_q, msCnt_q, sweepLeft_q;
  logic        startPls_q, align_q, alert_q, uncal_q;

  wire negDelay  = delay_q[31];
  wire posDelay  = ~negDelay & (delay_q != 32'h0000_0000);
  wire [31:0] preMag = 32'h0000_0000 - delay_q;
  wire msTick    = (msCnt_q == 32'(MS_CYCLES - 1));
  wire sweepDone = (state_q == ST_SWEEP) & msTick &
                   (sweepLeft_q <= 32'h0000_0001);
  wire delayDone = (state_q == ST_DELAY) &
                   (delayCnt_q <= 32'h0000_0001);
  // armed start: free runs immediately, others wait for a hit
  wire armGo    = (state_q == ST_ARMED) & runEn & (effFree | trigHit);
  wire armDirect = armGo & (effFree | ~posDelay);
  // back-to-back restart at sweep end keeps free run gapless
  wire freeAgain = sweepDone & runEn & effFree;
  wire startNow = armDirect | delayDone | freeAgain;

  // next state; hits during delay or sweep are not looked at
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (runEn) state_d = ST_ARMED;
      end
      ST_ARMED: begin
        if (!runEn) state_d = ST_IDLE;
        else if (armDirect) state_d = ST_SWEEP;
        else if (armGo) state_d = ST_DELAY;
      end
      ST_DELAY: begin
        if (delayDone) state_d = ST_SWEEP;
      end
      ST_SWEEP: begin
        if (freeAgain) state_d = ST_SWEEP;
        else if (sweepDone) state_d = runEn ? ST_ARMED : ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) state_q <= ST_IDLE;
    else        state_q <= state_d;
  end

  // delay countdown loaded by the qualifying trigger
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      delayCnt_q <= 32'h0000_0000;
    end else if (armGo && !armDirect) begin
      delayCnt_q <= delay_q;
    end else if (state_q == ST_DELAY) begin
      delayCnt_q <= delayCnt_q - 32'h0000_0001;
    end
  end

  // millisecond prescaler and remaining sweep time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      msCnt_q     <= 32'h0000_0000;
      sweepLeft_q <= 32'h0000_0000;
    end else if (startNow) begin
      msCnt_q     <= 32'h0000_0000;
      sweepLeft_q <= (sweepMs == 32'h0000_0000) ? `SWTC_RST_ONE : sweepMs;
    end else if (state_q == ST_SWEEP) begin
      msCnt_q     <= msTick ? 32'h0000_0000 : msCnt_q + 32'h0000_0001;
      sweepLeft_q <= msTick ? sweepLeft_q - 32'h0000_0001 : sweepLeft_q;
    end
  end

  // start strobes and per-sweep flags, fixed for the whole sweep
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      startPls_q <= 1'b0;
      align_q    <= 1'b0;
      alert_q    <= 1'b0;
      uncal_q    <= 1'b0;
    end else begin
      startPls_q <= startNow;
      align_q    <= startNow;
      if (startNow) begin
        alert_q <= (sweepMs > `SWTC_LONG_MS);
        uncal_q <= (sweepMs > `SWTC_UNCAL_MS);
      end else if (sweepDone) begin
        alert_q <= 1'b0;
        uncal_q <= 1'b0;
      end
    end
  end

  // pre-trigger length for the capture path, latched at start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      preTrigCycles <= 32'h0000_0000;
    end else if (startNow) begin
      preTrigCycles <= (negDelay & ~effFree) ? preMag
                                             : 32'h0000_0000;
    end
  end

  // sticky notice: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      notice_q <= 1'b0;
    end else if (noticeSet) begin
      notice_q <= 1'b1;
    end else if (wrStatus && wbReq.sel[0] &&
                 wbReq.dat[`SWTC_ST_NOTICE]) begin
      notice_q <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sweepActive    <= 1'b0;
      manualTimeFlag <= 1'b0;
      trigNoticeFlag <= 1'b0;
      zeroSpanActive <= 1'b0;
    end else begin
      sweepActive    <= (state_d == ST_SWEEP);
      manualTimeFlag <= manAcq & ~zeroSpan;
      trigNoticeFlag <= notice_q | noticeSet;
      zeroSpanActive <= zeroSpan;
    end
  end

  assign wbAck            = ack_q;
  assign wbDat            = dat_q;
  assign sweepStartPulse  = startPls_q;
  assign alignPulse       = align_q;
  assign longSweepAlert   = alert_q;
  assign uncalibratedFlag = uncal_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence sFreeEnd;
    sweepDone && runEn && effFree;
  endsequence
  sequence sStartOut;
    ##1 sweepStartPulse && alignPulse;
  endsequence

  a_free_restart: assert property (sFreeEnd |-> sStartOut)
    else $error("free run did not restart at sweep end");
  a_step_free: assert property (
    (state_q == ST_ARMED) && runEn && stepped |=> state_q == ST_SWEEP)
    else $error("stepped sweep waited for a trigger");
  a_step_notice: assert property (
    stepped && trigType != TRG_FREE |=> trigNoticeFlag && notice_q)
    else $error("no notice for trigger in stepped sweep");
  a_edge_only: assert property (
    (state_q == ST_ARMED) && runEn && !effFree && !isPer && !trigHit
    |=> state_q != ST_SWEEP && state_q != ST_DELAY)
    else $error("sweep started without a qualifying edge");
  a_per_phase: assert property (
    isPer && perCnt_q == offset_q && state_q == ST_ARMED && runEn &&
    !posDelay |=> sweepStartPulse)
    else $error("periodic trigger missed its phase");
  a_sync_reset: assert property (
    syncHit |=> perCnt_q == 32'h0000_0000)
    else $error("sync did not restart the period");
  a_delay_wait: assert property (
    (state_q == ST_ARMED) && armGo && !armDirect &&
    delay_q == 32'h0000_0005
    |=> !startNow [*4] ##1 startNow)
    else $error("trigger delay length wrong");
  a_no_rearm: assert property (
    state_q == ST_DELAY && !delayDone |=> !sweepStartPulse)
    else $error("trigger accepted during delay");
  a_alert_hold: assert property (
    longSweepAlert && state_q == ST_SWEEP && !sweepDone
    |=> longSweepAlert)
    else $error("long sweep alert dropped mid sweep");
  a_uncal_set: assert property (
    startNow && sweepMs > `SWTC_UNCAL_MS |=> uncalibratedFlag)
    else $error("uncalibrated flag not raised");
  a_zs_clamp: assert property (
    zeroSpan |-> sweepMs <= zsMax)
    else $error("zero span sweep time not clamped");
  a_span_tog: assert property (
    wrToggle && !wrSpan && span_q != 32'h0000_0000
    |=> span_q == 32'h0000_0000)
    else $error("span toggle did not go to zero");

endmodule

// [swtc_far_model.sv]
// far side of the sweep trigger block: trigger source and comparators
// assumes: the bench moves lvl just after a rising edge of mclk
`timescale 1ns/1ps
module swtc_far_model (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [3:0] lvl,
  output logic            extTrigIn,
  output logic            videoAboveLevel,
  output logic            ifLevelAboveLevel,
  output logic            satnavSecondPulse
);
  logic [3:0] lvl_q;
  // ---------------------------------------------
  // comparator outputs
  // ---------------------------------------------
  // one cycle of settling, so no edge lands beside its stimulus
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lvl_q <= 4'h0;
    else lvl_q <= lvl;
  end
  // bit 0 external, 1 video, 2 third-if, 3 second pulse
  assign extTrigIn         = lvl_q[0];
  assign videoAboveLevel   = lvl_q[1];
  assign ifLevelAboveLevel = lvl_q[2];
  assign satnavSecondPulse = lvl_q[3];
endmodule

// [swtc_pkg.sv]
// types shared by the sweep trigger control block
// assumes: compiled before the design module
package swtc_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } swtc_wbreq_type;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_DELAY = 2'b10,
    ST_SWEEP = 2'b11
  } swtc_state_type;
  typedef enum logic [2:0] {
    TRG_FREE  = 3'b000,
    TRG_EXT   = 3'b001,
    TRG_PER   = 3'b010,
    TRG_VIDEO = 3'b011,
    TRG_IFLVL = 3'b100
  } swtc_trig_type;
  typedef enum logic [1:0] {
    SYN_NONE  = 2'b00,
    SYN_EXT   = 2'b01,
    SYN_IFLVL = 2'b10,
    SYN_SAT   = 2'b11
  } swtc_sync_type;
endpackage

// [swtc_regs.svh]
// register map, field positions, reset values and timing constants
// assumes: included by bare name from the sweep trigger design files
`ifndef SWTC_REGS_SVH
`define SWTC_REGS_SVH
// byte offsets on the classic wishbone slave, one word each
`define SWTC_OFF_CTRL    6'h00
`define SWTC_OFF_DELAY   6'h04
`define SWTC_OFF_PERIOD  6'h08
`define SWTC_OFF_OFFSET  6'h0C
`define SWTC_OFF_ACQ     6'h10
`define SWTC_OFF_AUTOACQ 6'h14
`define SWTC_OFF_BASEMS  6'h18
`define SWTC_OFF_ZSTIME  6'h1C
`define SWTC_OFF_SPAN    6'h20
`define SWTC_OFF_TOGGLE  6'h24
`define SWTC_OFF_STATUS  6'h28
`define SWTC_OFF_SWPMS   6'h2C
// control fields
`define SWTC_CTRL_RUN    0
`define SWTC_CTRL_TYP_LO 1
`define SWTC_CTRL_TYP_HI 3
`define SWTC_CTRL_NEG    4
`define SWTC_CTRL_SYN_LO 5
`define SWTC_CTRL_SYN_HI 6
`define SWTC_CTRL_STEP   7
`define SWTC_CTRL_MAN    8
`define SWTC_CTRL_BIG    9
// status fields
`define SWTC_ST_NOTICE   3
// reset values
`define SWTC_RST_PERIOD  32'h003D_0900
`define SWTC_RST_ONE     32'h0000_0001
// acquisition limits
`define SWTC_ACQ_MIN     32'h0000_0001
`define SWTC_ACQ_MAX     32'h0000_1388
// times in milliseconds
`define SWTC_LONG_MS     32'h0012_4F80
`define SWTC_UNCAL_MS    32'h003D_0900
`define SWTC_ZS_SMALL_MS 32'h000F_4240
`define SWTC_ZS_BIG_MS   32'h005B_8D80
// clock period and millisecond length in ns
`define SWTC_CLK_NS      32'h0000_0005
`define SWTC_MS_NS       32'h000F_4240
`endif

// [testbench.sv]
// self-checking bench for sweep_trigger_control
// assumes: package, design and far side model compiled before it
`timescale 1ns/1ps
module testbench;
  import swtc_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_b = 1'b0;
  swtc_wbreq_type wbReq = '0;
  logic [3:0]     lvl = 4'h0;
  logic [31:0]    wbDat, preTrigCycles, rdDat;
  logic           wbAck, sweepStartPulse, alignPulse, sweepActive;
  logic           longSweepAlert, uncalibratedFlag, trigNoticeFlag;
  logic           manualTimeFlag, zeroSpanActive;
  logic           extTrigIn, videoAboveLevel;
  logic           ifLevelAboveLevel, satnavSecondPulse;
  int             n_mismatch = 0, n_checks = 0, k, n, n0;
  // ---------------------------------------------
  // register rows: we, offset, write data or read value
  // ---------------------------------------------
  localparam logic [38:0] ROWS [30] = '{
    {1'b0,6'h00,32'h0000_0000}, {1'b0,6'h04,32'h0000_0000},
    {1'b0,6'h08,32'h003D_0900}, {1'b0,6'h0C,32'h0000_0000},
    {1'b0,6'h10,32'h0000_0001}, {1'b0,6'h14,32'h0000_0001},
    {1'b0,6'h18,32'h0000_0001}, {1'b0,6'h1C,32'h0000_0001},
    {1'b0,6'h20,32'h0000_0000}, {1'b0,6'h30,32'h0000_0000},
    {1'b1,6'h00,32'h0000_0100},
    {1'b1,6'h10,32'h0000_1770}, {1'b0,6'h10,32'h0000_1388},
    {1'b1,6'h10,32'h0000_0000}, {1'b0,6'h10,32'h0000_0001},
    {1'b1,6'h1C,32'h001E_8480}, {1'b0,6'h1C,32'h000F_4240},
    {1'b1,6'h00,32'h0000_0200}, {1'b1,6'h1C,32'h006A_CFC0},
    {1'b0,6'h1C,32'h005B_8D80},
    {1'b1,6'h20,32'h0000_0005}, {1'b1,6'h24,32'h0000_0000},
    {1'b0,6'h20,32'h0000_0000}, {1'b1,6'h24,32'h0000_0000},
    {1'b0,6'h20,32'h0000_0005}, {1'b1,6'h00,32'h0000_0100},
    {1'b0,6'h28,32'h0000_0010},
    {1'b1,6'h14,32'h0000_000A}, {1'b1,6'h10,32'h0000_0003},
    {1'b0,6'h10,32'h0000_000A}};

  sweep_trigger_control #(.MS_CYCLES(4)) sweep_trigger_control_i (
    .mclk, .rst_b, .wbReq, .wbAck, .wbDat, .extTrigIn, .videoAboveLevel,
    .ifLevelAboveLevel, .satnavSecondPulse, .sweepStartPulse,
    .alignPulse, .sweepActive, .longSweepAlert, .uncalibratedFlag,
    .trigNoticeFlag, .manualTimeFlag, .zeroSpanActive, .preTrigCycles);
  swtc_far_model swtc_far_model_i (.mclk, .rst_b, .lvl, .extTrigIn,
    .videoAboveLevel, .ifLevelAboveLevel, .satnavSecondPulse);

  // free-running 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; the answer latency is never assumed
  task wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    wbReq <= '{1'b1, 1'b1, we, 4'hF, a, d};
    for (i = 0; i < 20 && wbAck !== 1'b1; i++) @(posedge mclk);
    rdDat = wbDat;
    wbReq <= '0;
    if (i == 20) begin
      n_mismatch++;
      test_done;
    end
  endtask
  // edges until a start pulse; 40 means none came
  task waitPulse(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (sweepStartPulse !== 1'b1 && c < 40);
    chk(alignPulse, sweepStartPulse);
  endtask
  task hit(input int b, output int c);
    @(posedge mclk);
    lvl[b] <= ~lvl[b];
    waitPulse(c);
  endtask
  task gap(output int c);
    waitPulse(c);
    waitPulse(c);
  endtask
  task doReset;
    @(posedge mclk);
    rst_b <= 1'b0;
    lvl <= 4'h0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
  endtask
  // alert and uncal are judged at sweep start, then reset aborts;
  // a nonzero span makes the factor product the sweep time
  task longCase(input logic [31:0] ms, input logic a, input logic u);
    wb(1'b1, 6'h20, 32'h0000_0001);
    wb(1'b1, 6'h18, ms);
    wb(1'b1, 6'h00, 32'h0000_0001);
    waitPulse(n);
    @(posedge mclk);
    chk(longSweepAlert, a);
    chk(uncalibratedFlag, u);
    chk({sweepActive, zeroSpanActive, manualTimeFlag}, 3'b100);
    doReset;
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    chk({sweepActive, trigNoticeFlag, zeroSpanActive, wbAck}, 0);
    rst_b <= 1'b1;
    foreach (ROWS[r]) begin
      wb(ROWS[r][38], ROWS[r][37:32], ROWS[r][31:0]);
      if (!ROWS[r][38]) chk(rdDat, ROWS[r][31:0]);
    end
    chk({manualTimeFlag, zeroSpanActive}, 2'b10);
    doReset;
    // external, video and third-if types, rising slope
    for (k = 0; k < 3; k++) begin
      wb(1'b1, 6'h00, 32'((k == 0 ? 1 : k + 2) * 2 + 1));
      hit(k, n);
      chk(n < 40, 1'b1);
      if (k == 0) n0 = n;
      repeat (8) @(posedge mclk);
      hit(k, n);
      chk(n, 40);
    end
    wb(1'b1, 6'h00, 32'h0000_0013);
    hit(0, n);
    chk(n, 40);
    hit(0, n);
    chk(n, n0);
    repeat (8) @(posedge mclk);
    wb(1'b1, 6'h04, 32'h0000_0005);
    wb(1'b1, 6'h00, 32'h0000_0003);
    hit(0, n);
    chk(n, n0 + 5);
    repeat (12) @(posedge mclk);
    wb(1'b1, 6'h04, 32'hFFFF_FFFD);
    hit(0, n);
    hit(0, n);
    @(posedge mclk);
    chk(n, n0);
    chk(preTrigCycles, 32'h0000_0003);
    wb(1'b1, 6'h00, 32'h0000_0001);
    gap(n);
    chk(n, 4);
    wb(1'b1, 6'h00, 32'h0000_0083);
    gap(n);
    chk(n, 4);
    chk(trigNoticeFlag, 1'b1);
    wb(1'b1, 6'h08, 32'h0000_000A);
    wb(1'b1, 6'h00, 32'h0000_0015);
    gap(n);
    chk(n, 10);
    // second pulse sync restarts the phase: start four edges later
    wb(1'b1, 6'h00, 32'h0000_0065);
    hit(3, n);
    chk(n, 4);
    doReset;
    longCase(32'h0012_4F80, 1'b0, 1'b0);
    longCase(32'h003D_0900, 1'b1, 1'b0);
    longCase(32'h003D_0901, 1'b1, 1'b1);
    test_done;
  end
endmodule
